// ---- scpisr_regs.vh ----
// Constants of the status reporting register block.
`ifndef SCPISR_REGS_VH
`define SCPISR_REGS_VH

// ==========================================================================
// Host command codes
// ==========================================================================
`define SCPISR_CMD_RD_EVENT 4'h0
`define SCPISR_CMD_RD_COND 4'h1
`define SCPISR_CMD_RD_ENABLE 4'h2
`define SCPISR_CMD_WR_ENABLE 4'h3
`define SCPISR_CMD_RD_STB 4'h4
`define SCPISR_CMD_CLS 4'h5
`define SCPISR_CMD_OPC 4'h6

// ==========================================================================
// Register set selectors
// ==========================================================================
`define SCPISR_SET_OPER 4'h0
`define SCPISR_SET_QUES 4'h1
`define SCPISR_SET_SRC_OPER0 4'h2
`define SCPISR_SET_MEAS_OPER0 4'h5
`define SCPISR_SET_SRC_QUES0 4'h8
`define SCPISR_SET_MEAS_QUES0 4'hB
`define SCPISR_SET_STD 4'hE
`define SCPISR_SET_SRE 4'hF

// ==========================================================================
// Status byte bit positions
// ==========================================================================
`define SCPISR_STB_EAV 2
`define SCPISR_STB_QSB 3
`define SCPISR_STB_MAV 4
`define SCPISR_STB_ESB 5
`define SCPISR_STB_MSS 6
`define SCPISR_STB_OSB 7

// ==========================================================================
// Standard event bit positions
// ==========================================================================
`define SCPISR_STD_OPC 0
`define SCPISR_STD_QYE 2
`define SCPISR_STD_DSE 3
`define SCPISR_STD_EXE 4
`define SCPISR_STD_CME 5
`define SCPISR_STD_PON 7

// ==========================================================================
// Implemented bit masks and reset values
// ==========================================================================
`define SCPISR_MASK_OPER 16'h007F
`define SCPISR_MASK_QUES 16'h07FF
`define SCPISR_MASK_SRC_OPER 16'h0007
`define SCPISR_MASK_MEAS_OPER 16'h0007
`define SCPISR_MASK_MOD_QUES 16'h001F
`define SCPISR_MASK_STD 16'h00BD
`define SCPISR_RST_ENABLE 16'h0000
`define SCPISR_RST_SRE 8'h00

`endif

// ---- scpisr_evset.v ----
// One condition, event and enable register set with its summary output.
`timescale 1ns/100ps
`include "scpisr_regs.vh"

module scpisr_evset #(
  parameter [15:0] MASK = 16'hFFFF
) (
  input wire I_CLK_SYS, // System clock.
  input wire I_RSTN, // Synchronous reset, active low.
  input wire [15:0] i_cond, // Live condition bits.
  input wire [15:0] i_set, // Direct event pulses.
  input wire i_en_wr, // Enable register write strobe.
  input wire [15:0] i_wdata, // Enable register write data.
  input wire i_clr, // Event clear strobe.
  output wire [15:0] o_cond, // Masked condition bits.
  output reg [15:0] o_event, // Latched event bits.
  output reg [15:0] o_enable, // Enable mask.
  output wire o_summary // Enabled event summary.
);

  reg [15:0] cond_prev;
  wire [15:0] rise;
  wire [15:0] next_event;

  // Condition bits pass straight through, unlatched.
  assign o_cond = i_cond & MASK;
  assign rise = (i_cond & ~cond_prev) | i_set;
  // A new event in the clearing cycle survives the clear.
  assign next_event = ((o_event & ~{16{i_clr}}) | rise) & MASK;
  assign o_summary = |(o_event & o_enable);

  // Event latch, edge history and enable mask.
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
    begin
      cond_prev <= 16'h0000;
      o_event <= 16'h0000;
      o_enable <= `SCPISR_RST_ENABLE;
    end
    else
    begin
      cond_prev <= i_cond;
      o_event <= next_event;
      if (i_en_wr)
        o_enable <= i_wdata & MASK;
    end
  end

endmodule // scpisr_evset

// ---- scpisr_stb.v ----
// Status byte composition from the summary sources.
`timescale 1ns/100ps
`include "scpisr_regs.vh"

module scpisr_stb (
  input wire i_osb, // Operation summary.
  input wire i_esb, // Standard event summary.
  input wire i_mav, // Message available.
  input wire i_qsb, // Questionable summary.
  input wire i_eav, // Error available.
  input wire [7:0] i_sre, // Service request enable mask.
  output wire [7:0] o_stb // Status byte.
);

  wire [7:0] summ;

  // Summary bits follow their sources without latching.
  assign summ = {i_osb, 1'b0, i_esb, i_mav, i_qsb, i_eav, 2'b00};
  // Master summary: any summary bit with its enable set.
  assign o_stb = summ | ({7'h00, |(summ & i_sre)} << `SCPISR_STB_MSS);

endmodule // scpisr_stb

// ---- scpisr_status.v ----
// Status reporting register block: status byte, standard, operation and questionable sets.
`timescale 1ns/100ps
`include "scpisr_regs.vh"


module scpisr_status (
  input wire I_CLK_SYS, // System clock, 10 MHz.
  input wire I_RSTN, // Synchronous reset, active low.
  input wire I_CMD_STB, // Host command strobe, one cycle.
  input wire [3:0] I_CMD_OP, // Host command code.
  input wire [3:0] I_CMD_SET, // Register set selector.
  input wire [15:0] I_CMD_DATA, // Enable write data.
  input wire I_MSG_PENDING, // Output buffer holds a message.
  input wire I_ERRQ_NOT_EMPTY, // Error queue holds an error.
  input wire I_CMD_ERROR, // Command error pulse.
  input wire I_EXEC_ERROR, // Execution error pulse.
  input wire I_DEVICE_SPECIFIC_FAULT, // Device specific error pulse.
  input wire I_QUERY_ERROR, // Query error pulse.
  input wire I_OPS_PENDING, // Operations still pending.
  input wire [2:0] I_VOLTAGE_LIMIT_ACTIVE, // Per source module.
  input wire [2:0] I_CURRENT_LIMIT_ACTIVE, // Per source module.
  input wire [2:0] I_SWEEP_ACTIVE, // Per source module.
  input wire [2:0] I_OVER_RANGE_FLAG, // Per measure module.
  input wire [2:0] I_HW_SETTLING_FLAG, // Per measure module.
  input wire [2:0] I_REFERENCE_UNLOCKED, // Per measure module.
  input wire [5:0] I_MODULE_COMM_FAIL, // Source 0-2, measure 3-5.
  input wire [5:0] I_UNSUPPORTED_MODULE, // Source 0-2, measure 3-5.
  input wire [5:0] I_WRONG_PORT_TYPE, // Source 0-2, measure 3-5.
  input wire [5:0] I_FACTORY_CAL_FAIL, // Source 0-2, measure 3-5.
  input wire [5:0] I_SELF_CAL_FAIL, // Source 0-2, measure 3-5.
  input wire I_STREAM_ACTIVE, // Data stream in progress.
  input wire I_STARTUP_HW_FAULT, // Startup hardware fault.
  input wire I_RUNTIME_HW_FAULT, // Runtime hardware fault.
  input wire I_INTERNAL_LINK_LOST, // Internal communication lost.
  input wire I_CAL_DATA_BAD, // Corrupt or default calibration.
  input wire I_STREAM_OVERFLOW_FLAG, // Stream data lost.
  output wire [7:0] O_STATUS_BYTE, // Live status byte.
  output reg O_RSP_STB, // Response valid pulse.
  output reg [15:0] O_RSP_DATA // Response value.
);

  // ========================================================================
  // Declarations
  // ========================================================================
  localparam SYNC_W = 54;
  localparam NSET = 15;

  reg [SYNC_W-1:0] sync_a;
  reg [SYNC_W-1:0] sync_b;
  reg [7:0] sre;
  reg pon_done;
  reg opc_armed;
  wire [SYNC_W-1:0] hw_raw;
  wire [255:0] cond_in;
  wire [255:0] set_in;
  wire [255:0] cond_all;
  wire [255:0] event_all;
  wire [255:0] enable_all;
  wire [15:0] summ_all;
  wire [NSET-1:0] clr;
  wire [NSET-1:0] en_wr;
  wire [2:0] src_voltage_limit_active;
  wire [2:0] src_current_limit_active;
  wire [2:0] src_sweep_active;
  wire [2:0] meas_over_range_flag;
  wire [2:0] meas_hw_settling_flag;
  wire [2:0] meas_reference_unlocked;
  wire [5:0] mod_comm_fail;
  wire [5:0] mod_unsupported_module;
  wire [5:0] mod_wrong_port_type;
  wire [5:0] mod_factory_cal_fail;
  wire [5:0] mod_self_cal_fail;
  wire stream_active;
  wire startup_hw_fault;
  wire runtime_hw_fault;
  wire internal_link_lost;
  wire cal_data_bad;
  wire stream_overflow_flag;
  wire [2:0] src_oper_summ;
  wire [2:0] meas_oper_summ;
  wire [2:0] src_ques_summ;
  wire [2:0] meas_ques_summ;
  wire pon_pulse;
  wire opc_done;
  wire cls_cmd;
  wire [15:0] std_set;

  // ========================================================================
  // Functions
  // ========================================================================
  // True when a command strobe carries the given code for the given set.
  function hit;
    input stb;
    input [3:0] op;
    input [3:0] set;
    input [3:0] want_op;
    input [3:0] want_set;
    begin
      hit = stb & (op == want_op) & (set == want_set);
    end
  endfunction

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  // Hardware status lines arrive from other logic and pins.
  assign hw_raw = {I_STREAM_OVERFLOW_FLAG, I_CAL_DATA_BAD, I_INTERNAL_LINK_LOST,
    I_RUNTIME_HW_FAULT, I_STARTUP_HW_FAULT, I_STREAM_ACTIVE,
    I_SELF_CAL_FAIL, I_FACTORY_CAL_FAIL, I_WRONG_PORT_TYPE,
    I_UNSUPPORTED_MODULE, I_MODULE_COMM_FAIL,
    I_REFERENCE_UNLOCKED, I_HW_SETTLING_FLAG, I_OVER_RANGE_FLAG,
    I_SWEEP_ACTIVE, I_CURRENT_LIMIT_ACTIVE, I_VOLTAGE_LIMIT_ACTIVE};

  // Two flip-flop stages before any logic looks at a hardware line.
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
    begin
      sync_a <= {SYNC_W{1'b0}};
      sync_b <= {SYNC_W{1'b0}};
    end
    else
    begin
      sync_a <= hw_raw;
      sync_b <= sync_a;
    end
  end

  // Split the synchronised vector back into named lines.
  assign {stream_overflow_flag, cal_data_bad, internal_link_lost, runtime_hw_fault,
    startup_hw_fault, stream_active, mod_self_cal_fail, mod_factory_cal_fail,
    mod_wrong_port_type, mod_unsupported_module, mod_comm_fail,
    meas_reference_unlocked, meas_hw_settling_flag, meas_over_range_flag,
    src_sweep_active, src_current_limit_active, src_voltage_limit_active} = sync_b;

  // ========================================================================
  // Module summaries
  // ========================================================================
  // Each module summary is its set's enabled event OR.
  assign src_oper_summ = summ_all[4:2];
  assign meas_oper_summ = summ_all[7:5];
  assign src_ques_summ = summ_all[10:8];
  assign meas_ques_summ = summ_all[13:11];

  // ========================================================================
  // Condition inputs of the register sets
  // ========================================================================
  // Top operation set: module summaries and stream activity.
  assign cond_in[15:0] = {9'h000, stream_active, meas_oper_summ, src_oper_summ};

  // Top questionable set: module summaries and instrument faults.
  assign cond_in[31:16] = {5'h00, stream_overflow_flag, cal_data_bad,
    internal_link_lost, runtime_hw_fault, startup_hw_fault,
    meas_ques_summ, src_ques_summ};

  // Per-module operation and questionable sets.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_mod
      assign cond_in[(2+g)*16 +: 16] = {13'h0000, src_sweep_active[g],
        src_current_limit_active[g], src_voltage_limit_active[g]};
      assign cond_in[(5+g)*16 +: 16] = {13'h0000, meas_reference_unlocked[g],
        meas_hw_settling_flag[g], meas_over_range_flag[g]};
      assign cond_in[(8+g)*16 +: 16] = {11'h000, mod_self_cal_fail[g],
        mod_factory_cal_fail[g], mod_wrong_port_type[g],
        mod_unsupported_module[g], mod_comm_fail[g]};
      assign cond_in[(11+g)*16 +: 16] = {11'h000, mod_self_cal_fail[3+g],
        mod_factory_cal_fail[3+g], mod_wrong_port_type[3+g],
        mod_unsupported_module[3+g], mod_comm_fail[3+g]};
    end
  endgenerate

  // The standard event set has no condition register.
  assign cond_in[255:224] = 32'h00000000;

  // ========================================================================
  // Standard event sources
  // ========================================================================
  // Power on and operation complete pulses join the error classes.
  assign std_set = ({15'h0000, pon_pulse} << `SCPISR_STD_PON)
    | ({15'h0000, I_CMD_ERROR} << `SCPISR_STD_CME)
    | ({15'h0000, I_EXEC_ERROR} << `SCPISR_STD_EXE)
    | ({15'h0000, I_DEVICE_SPECIFIC_FAULT} << `SCPISR_STD_DSE)
    | ({15'h0000, I_QUERY_ERROR} << `SCPISR_STD_QYE)
    | ({15'h0000, opc_done} << `SCPISR_STD_OPC);

  // Only the standard set takes direct event pulses.
  assign set_in[223:0] = 224'h0;
  assign set_in[239:224] = std_set;
  assign set_in[255:240] = 16'h0000;

  // The first cycle after reset release counts as the power-on transition.
  assign pon_pulse = ~pon_done;

  // Operation complete fires once the armed request sees no pending work.
  assign opc_done = opc_armed & ~I_OPS_PENDING;

  // Power-on and operation complete tracking.
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
    begin
      pon_done <= 1'b0;
      opc_armed <= 1'b0;
    end
    else
    begin
      pon_done <= 1'b1;
      if (hit(I_CMD_STB, I_CMD_OP, 4'h0, `SCPISR_CMD_OPC, 4'h0))
        opc_armed <= 1'b1;
      else if (opc_done | cls_cmd)
        opc_armed <= 1'b0;
    end
  end

  // ========================================================================
  // Command decode
  // ========================================================================
  // Clear-status clears every event register at once.
  assign cls_cmd = hit(I_CMD_STB, I_CMD_OP, 4'h0, `SCPISR_CMD_CLS, 4'h0);

  // Per-set clearing read and enable write strobes.
  generate
    for (g = 0; g < NSET; g = g + 1)
    begin : g_dec
      localparam [3:0] SEL = g;
      assign clr[g] = cls_cmd
        | hit(I_CMD_STB, I_CMD_OP, I_CMD_SET, `SCPISR_CMD_RD_EVENT, SEL);
      assign en_wr[g] = hit(I_CMD_STB, I_CMD_OP, I_CMD_SET,
        `SCPISR_CMD_WR_ENABLE, SEL);
    end
  endgenerate

  // ========================================================================
  // Register sets
  // ========================================================================
  // Fifteen condition, event and enable sets, each with its own mask.
  generate
    for (g = 0; g < NSET; g = g + 1)
    begin : g_set
      localparam [15:0] MSK = (g == 0) ? `SCPISR_MASK_OPER :
        (g == 1) ? `SCPISR_MASK_QUES :
        (g < 5) ? `SCPISR_MASK_SRC_OPER :
        (g < 8) ? `SCPISR_MASK_MEAS_OPER :
        (g < 14) ? `SCPISR_MASK_MOD_QUES : `SCPISR_MASK_STD;
      scpisr_evset #(
        .MASK(MSK)
      ) u_set (
        .I_CLK_SYS(I_CLK_SYS),
        .I_RSTN(I_RSTN),
        .i_cond(cond_in[g*16 +: 16]),
        .i_set(set_in[g*16 +: 16]),
        .i_en_wr(en_wr[g]),
        .i_wdata(I_CMD_DATA),
        .i_clr(clr[g]),
        .o_cond(cond_all[g*16 +: 16]),
        .o_event(event_all[g*16 +: 16]),
        .o_enable(enable_all[g*16 +: 16]),
        .o_summary(summ_all[g])
      );
    end
  endgenerate

  // Slot 15 is the service request mask, with no event or condition.
  assign cond_all[255:240] = 16'h0000;
  assign event_all[255:240] = 16'h0000;
  assign enable_all[255:240] = {8'h00, sre};
  assign summ_all[15] = 1'b0;

  // Service request enable mask, stored as written.
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
      sre <= `SCPISR_RST_SRE;
    else if (hit(I_CMD_STB, I_CMD_OP, I_CMD_SET, `SCPISR_CMD_WR_ENABLE, `SCPISR_SET_SRE))
      sre <= I_CMD_DATA[7:0];
  end

  // ========================================================================
  // Status byte
  // ========================================================================
  // Summaries feed the status byte directly, so clears show at once.
  scpisr_stb u_stb (
    .i_osb(summ_all[`SCPISR_SET_OPER]),
    .i_esb(summ_all[`SCPISR_SET_STD]),
    .i_mav(I_MSG_PENDING),
    .i_qsb(summ_all[`SCPISR_SET_QUES]),
    .i_eav(I_ERRQ_NOT_EMPTY),
    .i_sre(sre),
    .o_stb(O_STATUS_BYTE)
  );

  // ========================================================================
  // Query responses
  // ========================================================================
  // Reads answer one cycle after the strobe; writes and clears give none.
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
    begin
      O_RSP_STB <= 1'b0;
      O_RSP_DATA <= 16'h0000;
    end
    else
    begin
      O_RSP_STB <= 1'b0;
      if (I_CMD_STB)
      begin
        case (I_CMD_OP)
          `SCPISR_CMD_RD_EVENT:
          begin
            O_RSP_STB <= 1'b1;
            O_RSP_DATA <= event_all[{I_CMD_SET, 4'h0} +: 16];
          end
          `SCPISR_CMD_RD_COND:
          begin
            O_RSP_STB <= 1'b1;
            O_RSP_DATA <= cond_all[{I_CMD_SET, 4'h0} +: 16];
          end
          `SCPISR_CMD_RD_ENABLE:
          begin
            O_RSP_STB <= 1'b1;
            O_RSP_DATA <= enable_all[{I_CMD_SET, 4'h0} +: 16];
          end
          `SCPISR_CMD_RD_STB:
          begin
            O_RSP_STB <= 1'b1;
            O_RSP_DATA <= {8'h00, O_STATUS_BYTE};
          end
          default:
            O_RSP_STB <= 1'b0;
        endcase
      end
    end
  end

endmodule // scpisr_status

// ---- scpisr_status_asserts.sv ----
// Checker of the status reporting block's port behaviour.
`timescale 1ns/100ps

module scpisr_status_asserts (
  input wire I_CLK_SYS, // System clock.
  input wire I_RSTN, // Reset, active low.
  input wire I_CMD_STB, // Command strobe.
  input wire [3:0] I_CMD_OP, // Command code.
  input wire [3:0] I_CMD_SET, // Set selector.
  input wire [15:0] I_CMD_DATA, // Write data.
  input wire I_MSG_PENDING, // Message pending.
  input wire I_ERRQ_NOT_EMPTY, // Error queue flag.
  input wire [7:0] O_STATUS_BYTE, // Status byte.
  input wire O_RSP_STB, // Response pulse.
  input wire [15:0] O_RSP_DATA // Response value.
);
  // ==========================================================================
  // Helper terms and sequences
  // ==========================================================================
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RSTN);
  // A read request is any command that owes an answer.
  wire rd_req = I_CMD_STB && (I_CMD_OP <= 4'h2 || I_CMD_OP == 4'h4);
  sequence s_wr_sre;
    I_CMD_STB && I_CMD_OP == 4'h3 && I_CMD_SET == 4'hF;
  endsequence
  sequence s_rd_sre;
    I_CMD_STB && I_CMD_OP == 4'h2 && I_CMD_SET == 4'hF;
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_read_answers: assert property (rd_req |=> O_RSP_STB)
    else $error("read without answer");
  a_quiet_otherwise: assert property (!rd_req |=> !O_RSP_STB)
    else $error("answer without read");
  a_mav_live: assert property (O_STATUS_BYTE[4] == I_MSG_PENDING)
    else $error("message bit wrong");
  a_eav_live: assert property (O_STATUS_BYTE[2] == I_ERRQ_NOT_EMPTY)
    else $error("error bit wrong");
  a_unused_zero: assert property (O_STATUS_BYTE[1:0] == 2'b00)
    else $error("unused status bits set");
  a_stb_snapshot: assert property (I_CMD_STB && I_CMD_OP == 4'h4 |=>
    O_RSP_DATA == {8'h00, $past(O_STATUS_BYTE)}) else $error("status read wrong");
  a_sre_readback: assert property (s_wr_sre ##2 s_rd_sre |=>
    O_RSP_DATA == {8'h00, $past(I_CMD_DATA[7:0], 3)}) else $error("mask readback wrong");
  a_mss_masked_off: assert property (s_wr_sre and I_CMD_DATA[7:0] == 8'h00 |=>
    !O_STATUS_BYTE[6]) else $error("master bit without mask");
endmodule // scpisr_status_asserts

bind scpisr_status scpisr_status_asserts scpisr_status_asserts_i (
  .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_CMD_STB(I_CMD_STB), .I_CMD_OP(I_CMD_OP),
  .I_CMD_SET(I_CMD_SET), .I_CMD_DATA(I_CMD_DATA), .I_MSG_PENDING(I_MSG_PENDING),
  .I_ERRQ_NOT_EMPTY(I_ERRQ_NOT_EMPTY), .O_STATUS_BYTE(O_STATUS_BYTE),
  .O_RSP_STB(O_RSP_STB), .O_RSP_DATA(O_RSP_DATA));

// ---- scpisr_host_model.sv ----
// Host model that issues status commands and collects the answers.
`timescale 1ns/100ps
`include "scpisr_regs.vh"

module scpisr_host_model (
  input wire i_clk, // System clock.
  input wire i_rsp_stb, // Answer pulse.
  input wire [15:0] i_rsp_data, // Answer value.
  output logic o_cmd_stb, // Command strobe.
  output logic [3:0] o_cmd_op, // Command code.
  output logic [3:0] o_cmd_set, // Set selector.
  output logic [15:0] o_cmd_data, // Write data.
  output logic o_timeout // Answer never came.
);
  // ==========================================================================
  // Command issue
  // ==========================================================================
  // Idle state at time zero.
  initial
  begin
    o_cmd_stb = 1'b0;
    o_cmd_op = 4'h0;
    o_cmd_set = 4'h0;
    o_cmd_data = 16'h0000;
    o_timeout = 1'b0;
  end

  // One command, driven on a falling edge; reads wait a bounded time for the answer.
  task automatic cmd(input logic [3:0] op, input logic [3:0] set, input logic [15:0] data,
                     output logic [15:0] rsp);
    int i;
    @(negedge i_clk);
    o_cmd_stb = 1'b1;
    o_cmd_op = op;
    o_cmd_set = set;
    o_cmd_data = data;
    @(negedge i_clk);
    o_cmd_stb = 1'b0;
    o_cmd_data = ~data; // Unused data lines do not keep the old value.
    rsp = 16'h0000;
    if (op <= `SCPISR_CMD_WR_ENABLE - 4'h1 || op == `SCPISR_CMD_RD_STB)
    begin
      for (i = 0; i < 4 && i_rsp_stb !== 1'b1; i++)
        @(negedge i_clk);
      if (i_rsp_stb !== 1'b1)
        o_timeout = 1'b1;
      rsp = i_rsp_data;
    end
  endtask
endmodule // scpisr_host_model

// ---- scpisr_status_test.sv ----
// Self-checking bench of the status reporting block.
`timescale 1ns/100ps
`include "scpisr_regs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module scpisr_status_test;
  localparam logic [3:0] ev = `SCPISR_CMD_RD_EVENT;
  localparam logic [3:0] cd = `SCPISR_CMD_RD_COND;
  localparam logic [3:0] en = `SCPISR_CMD_RD_ENABLE;
  localparam logic [3:0] sb = `SCPISR_CMD_RD_STB;
  logic clk, rstn, msg, errq, ops, strm, sfault, rfault, link, cal, ovfl;
  logic [3:0] pu;
  logic [2:0] voltage_limit_active, current_limit_active, sweep_active, ovr, hw_settling_flag, reference_unlocked;
  logic [5:0] comm, unsup, wport, fcal, scal;
  wire cmd_stb, rsp_stb, to;
  wire [3:0] cmd_op, cmd_set;
  wire [15:0] cmd_data, rsp_data;
  wire [7:0] stat;
  int n_errors = 0;
  int check_count = 0;
  logic [15:0] cmd_rsp_unused;

  // ==========================================================================
  // Design, host model and clock
  // ==========================================================================
  scpisr_status scpisr_status_i (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_CMD_STB(cmd_stb),
    .I_CMD_OP(cmd_op), .I_CMD_SET(cmd_set), .I_CMD_DATA(cmd_data), .I_MSG_PENDING(msg),
    .I_ERRQ_NOT_EMPTY(errq), .I_CMD_ERROR(pu[0]), .I_EXEC_ERROR(pu[1]),
    .I_DEVICE_SPECIFIC_FAULT(pu[2]), .I_QUERY_ERROR(pu[3]), .I_OPS_PENDING(ops),
    .I_VOLTAGE_LIMIT_ACTIVE(voltage_limit_active), .I_CURRENT_LIMIT_ACTIVE(current_limit_active), .I_SWEEP_ACTIVE(sweep_active),
    .I_OVER_RANGE_FLAG(ovr), .I_HW_SETTLING_FLAG(hw_settling_flag), .I_REFERENCE_UNLOCKED(reference_unlocked),
    .I_MODULE_COMM_FAIL(comm), .I_UNSUPPORTED_MODULE(unsup), .I_WRONG_PORT_TYPE(wport),
    .I_FACTORY_CAL_FAIL(fcal), .I_SELF_CAL_FAIL(scal), .I_STREAM_ACTIVE(strm),
    .I_STARTUP_HW_FAULT(sfault), .I_RUNTIME_HW_FAULT(rfault), .I_INTERNAL_LINK_LOST(link),
    .I_CAL_DATA_BAD(cal), .I_STREAM_OVERFLOW_FLAG(ovfl), .O_STATUS_BYTE(stat),
    .O_RSP_STB(rsp_stb), .O_RSP_DATA(rsp_data));
  scpisr_host_model scpisr_host_model_i (.i_clk(clk), .i_rsp_stb(rsp_stb),
    .i_rsp_data(rsp_data), .o_cmd_stb(cmd_stb), .o_cmd_op(cmd_op), .o_cmd_set(cmd_set),
    .o_cmd_data(cmd_data), .o_timeout(to));
  // The clock toggles every half period of 50 ns.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Helper tasks
  // ==========================================================================
  task automatic chk_rd(input logic [3:0] op, input logic [3:0] set, input logic [15:0] exp);
    logic [15:0] r;
    scpisr_host_model_i.cmd(op, set, 16'h0000, r);
    `CHK(r, exp)
  endtask
  task automatic wr(input logic [3:0] set, input logic [15:0] d);
    logic [15:0] r;
    scpisr_host_model_i.cmd(`SCPISR_CMD_WR_ENABLE, set, d, r);
  endtask
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Power-on flag, clear on read, standard error classes, operation complete.
  task automatic t_standard();
    chk_rd(ev, 4'hE, 16'h0080);
    chk_rd(ev, 4'hE, 16'h0000);
    pu = 4'hF;
    @(negedge clk);
    pu = 4'h0;
    chk_rd(ev, 4'hE, 16'h003C);
    ops = 1'b1;
    wr(4'h0, 16'h0000);
    scpisr_host_model_i.cmd(`SCPISR_CMD_OPC, 4'h0, 16'h0000, cmd_rsp_unused);
    settle();
    chk_rd(ev, 4'hE, 16'h0000);
    ops = 1'b0;
    settle();
    chk_rd(ev, 4'hE, 16'h0001);
  endtask

  // Summary chain from a standard event to the master bit, and live clearing.
  task automatic t_summary();
    msg = 1'b1;
    errq = 1'b1;
    pu = 4'h2;
    @(negedge clk);
    pu = 4'h0;
    wr(4'hE, 16'h0010);
    wr(4'hF, 16'h0020);
    chk_rd(en, 4'hF, 16'h0020);
    chk_rd(sb, 4'h0, 16'h0074);
    chk_rd(en, 4'hE, 16'h0010);
    chk_rd(ev, 4'hE, 16'h0010);
    msg = 1'b0;
    errq = 1'b0;
    chk_rd(sb, 4'h0, 16'h0000);
    wr(4'hF, 16'h0000);
  endtask

  // Clear-status empties the standard event register but keeps its enable mask.
  task automatic t_clear();
    pu = 4'h1;
    @(negedge clk);
    pu = 4'h0;
    scpisr_host_model_i.cmd(`SCPISR_CMD_CLS, 4'h0, 16'h0000, cmd_rsp_unused);
    chk_rd(ev, 4'hE, 16'h0000);
    chk_rd(en, 4'hE, 16'h0010);
  endtask

  // Module operation flags into the top operation set and the status byte.
  task automatic t_operation();
    wr(4'h3, 16'h0007);
    wr(4'h0, 16'h007F);
    wr(4'hF, 16'h0080);
    current_limit_active = 3'h2;
    sweep_active = 3'h2;
    {ovr, hw_settling_flag, reference_unlocked} = 9'h124;
    strm = 1'b1;
    settle();
    chk_rd(cd, 4'h3, 16'h0006);
    chk_rd(cd, 4'h7, 16'h0007);
    chk_rd(cd, 4'h0, 16'h0042);
    chk_rd(sb, 4'h0, 16'h00C0);
    chk_rd(ev, 4'h0, 16'h0042);
    chk_rd(sb, 4'h0, 16'h0000);
  endtask

  // Module and top questionable flags into the questionable summary.
  task automatic t_questionable();
    wr(4'hC, 16'h001F);
    wr(4'h1, 16'h07FF);
    wr(4'hF, 16'h0008);
    {comm, unsup, wport, fcal, scal} = {5{6'h10}};
    {sfault, rfault, link, cal, ovfl} = 5'h1F;
    settle();
    chk_rd(cd, 4'hC, 16'h001F);
    chk_rd(cd, 4'h1, 16'h07D0);
    chk_rd(sb, 4'h0, 16'h0048);
    chk_rd(ev, 4'h1, 16'h07D0);
    chk_rd(sb, 4'h0, 16'h0000);
  endtask

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A missing answer counts as a mismatch and ends the run.
  always @(posedge to)
  begin
    n_errors++;
    report_and_stop();
  end
  // Main sequence: reset for 12 cycles, then the scenarios.
  initial
  begin
    {msg, errq, ops, strm, sfault, rfault, link, cal, ovfl, pu} = '0;
    {voltage_limit_active, current_limit_active, sweep_active, ovr, hw_settling_flag, reference_unlocked, comm, unsup, wport, fcal, scal} = '0;
    rstn = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_standard();
    t_summary();
    t_clear();
    t_operation();
    t_questionable();
    report_and_stop();
  end
endmodule // scpisr_status_test
